//--- hw/dcr_capture.sv
// load-enabled holding register for one trapped converter sample
// assumes load and d come from the sampling clock domain
`timescale 1ns/1ps

module dcr_capture #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// load strobe and data
	input wire logic load,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] q_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			q_reg <= '0;
		end else if (load) begin
			q_reg <= d;
		end
	end

	assign q = q_reg;
endmodule

//--- hw/dcr_digitizer_regs.sv
// control and status registers of the triple-channel digitizer
// assumes CLOCK is the sampling clock; serial bus and sync pins asynchronous
`timescale 1ns/1ps

module dcr_digitizer_regs (
	// clock and reset
	input wire logic CLOCK,
	input wire logic RST,
	// serial control bus, open drain data
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE_N,
	input wire logic ADDR_SELECT,
	// sync and clamp pins
	input wire logic HS_IN,
	input wire logic EXT_CLAMP_IN,
	input wire logic CSYNC_SLICE_IN,
	// converter samples
	input wire dcr_pkg::dcr_pixel_s SAMPLE_IN,
	// analog front-end controls
	output logic CLAMP_PULSE,
	output logic [2:0] CLAMP_CHANNEL_ENABLE,
	output logic [2:0] CLAMP_MID_RANGE,
	output dcr_pkg::dcr_chan_cfg_s [2:0] CHAN_CFG,
	output logic GLOBAL_POWER_DOWN,
	output logic REFERENCE_POWER_DOWN,
	output logic BANDGAP_POWER_DOWN,
	output logic CONVERTER_CLOCK_SELECT,
	output logic SYNTH_CLOCK_OUT,
	// sync outputs
	output logic COMPOSITE_SYNC_OUT,
	output logic DISPLAY_HSYNC_OUT,
	// pixel output buses
	output dcr_pkg::dcr_pixel_s BUS_A,
	output dcr_pkg::dcr_pixel_s BUS_B,
	output logic BUS_A_OE_N,
	output logic BUS_B_OE_N,
	output logic DATA_OUTPUT_CLOCK
);
	import dcr_pkg::*;

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic scl_s;
	logic sda_s;
	logic addr_sel_s;
	logic hs_s;
	logic ext_clamp_s;
	logic csync_s;

	dcr_sync3 #(.INIT(1'b1)) u_sync_scl (
		.clk(CLOCK), .rst(RST), .d(SCL_IN), .q(scl_s));
	dcr_sync3 #(.INIT(1'b1)) u_sync_sda (
		.clk(CLOCK), .rst(RST), .d(SDA_IN), .q(sda_s));
	dcr_sync3 #(.INIT(1'b0)) u_sync_asel (
		.clk(CLOCK), .rst(RST), .d(ADDR_SELECT), .q(addr_sel_s));
	dcr_sync3 #(.INIT(1'b0)) u_sync_hs (
		.clk(CLOCK), .rst(RST), .d(HS_IN), .q(hs_s));
	dcr_sync3 #(.INIT(1'b0)) u_sync_clp (
		.clk(CLOCK), .rst(RST), .d(EXT_CLAMP_IN), .q(ext_clamp_s));
	dcr_sync3 #(.INIT(1'b0)) u_sync_cs (
		.clk(CLOCK), .rst(RST), .d(CSYNC_SLICE_IN), .q(csync_s));

	// ------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------
	logic [7:0] bank_reg [BANK_SIZE];
	logic [7:0] pll_ctrl_reg;
	logic [7:0] output_format_control_reg;
	logic [7:0] readback [3];

	logic wr_stb;
	logic [7:0] wr_data;
	logic [7:0] sub_reg;
	logic [7:0] rd_data;

	wire logic [4:0] bank_idx = 5'(sub_reg - REG_BANK_FIRST);
	wire logic in_bank = (sub_reg >= REG_BANK_FIRST) &&
		(sub_reg <= REG_BANK_LAST);
	wire logic wr_bank = wr_stb && in_bank;
	wire logic wr_pll = wr_stb && (sub_reg == REG_PLL_CONTROL);
	wire logic wr_ofm = wr_stb && (sub_reg == REG_OUTPUT_FORMAT);

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			bank_reg <= BANK_RESET;
		end else if (wr_bank) begin
			bank_reg[bank_idx] <= wr_data & BANK_MASK[bank_idx];
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			pll_ctrl_reg <= PLL_CONTROL_RESET;
			output_format_control_reg <= OUTPUT_FORMAT_RESET;
		end else begin
			if (wr_pll) begin
				pll_ctrl_reg <= wr_data & PLL_CONTROL_MASK;
			end
			if (wr_ofm) begin
				output_format_control_reg <= wr_data & OUTPUT_FORMAT_MASK;
			end
		end
	end

	// readback registers are read-only; writes to them are dropped
	always_comb begin
		if (sub_reg == REG_PLL_CONTROL) begin
			rd_data = pll_ctrl_reg;
		end else if (in_bank) begin
			rd_data = bank_reg[bank_idx];
		end else if (sub_reg == REG_CH1_READBACK) begin
			rd_data = readback[0];
		end else if (sub_reg == REG_CH2_READBACK) begin
			rd_data = readback[1];
		end else if (sub_reg == REG_CH3_READBACK) begin
			rd_data = readback[2];
		end else if (sub_reg == REG_OUTPUT_FORMAT) begin
			rd_data = output_format_control_reg;
		end else begin
			rd_data = 8'h00;
		end
	end

	// ------------------------------------------------------------
	// field decode
	// ------------------------------------------------------------
	wire logic [7:0] clamp_ctrl = bank_reg[IDX_CLAMP_CONTROL];
	wire logic [7:0] power_down_control = bank_reg[IDX_POWER_DOWN];
	wire logic [11:0] clamp_begin_count =
		{bank_reg[IDX_BEGIN_HIGH][3:0], bank_reg[IDX_BEGIN_LOW]};
	wire logic [11:0] clamp_end_count =
		{bank_reg[IDX_END_HIGH][3:0], bank_reg[IDX_END_LOW]};
	wire logic [11:0] sample_capture_position =
		{bank_reg[IDX_TRAP_HIGH][3:0], bank_reg[IDX_TRAP_LOW]};
	wire logic clamp_source_select = clamp_ctrl[CLAMP_SOURCE_BIT];
	wire logic global_power_down = power_down_control[GLOBAL_PD_BIT];
	wire logic oscillator_disable = power_down_control[OSC_DISABLE_BIT];
	wire logic composite_sync_disable =
		bank_reg[IDX_AUX][CSYNC_DISABLE_BIT];
	wire logic display_sync_mode = output_format_control_reg[SYNC_MODE_BIT];
	wire logic display_sync_polarity = output_format_control_reg[SYNC_POLARITY_BIT];
	wire logic [1:0] output_format_mode = output_format_control_reg[1:0];

	assign GLOBAL_POWER_DOWN = global_power_down;
	assign REFERENCE_POWER_DOWN = power_down_control[REFERENCE_PD_BIT];
	assign BANDGAP_POWER_DOWN = power_down_control[BANDGAP_PD_BIT];
	assign CONVERTER_CLOCK_SELECT =
		pll_ctrl_reg[CONV_CLK_SELECT_BIT];
	assign CLAMP_CHANNEL_ENABLE = {clamp_ctrl[CLAMP_ENABLE_BIT3],
		clamp_ctrl[CLAMP_ENABLE_BIT2], clamp_ctrl[CLAMP_ENABLE_BIT1]};
	assign CLAMP_MID_RANGE = {clamp_ctrl[CLAMP_RANGE_BIT3],
		clamp_ctrl[CLAMP_RANGE_BIT2], clamp_ctrl[CLAMP_RANGE_BIT1]};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_chan
			localparam int BASE = IDX_CHAN_FIRST + gi * IDX_CHAN_STRIDE;
			assign CHAN_CFG[gi].clamp_level = bank_reg[BASE];
			assign CHAN_CFG[gi].gain_coarse = bank_reg[BASE + 1][5:0];
			assign CHAN_CFG[gi].gain_fine = bank_reg[BASE + 2][4:0];
		end
	endgenerate

	// ------------------------------------------------------------
	// serial control slave
	// ------------------------------------------------------------
	dcr_ser_state_e ser_state_reg;
	logic scl_prev_reg;
	logic sda_prev_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic [7:0] tx_reg;
	logic ack_low_reg;
	logic nack_reg;
	logic read_dir_reg;
	logic wr_stb_reg;

	wire logic scl_rise = scl_s && !scl_prev_reg;
	wire logic scl_fall = !scl_s && scl_prev_reg;
	wire logic bus_start = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
	wire logic bus_stop = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;
	wire logic byte_done = (bit_cnt_reg == 4'h8);
	wire logic [6:0] own_address =
		{DEVICE_ADDRESS_HIGH[6:1], addr_sel_s};

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			scl_prev_reg <= scl_s;
			sda_prev_reg <= sda_s;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			ser_state_reg <= SER_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			tx_reg <= 8'h00;
			ack_low_reg <= 1'b0;
			nack_reg <= 1'b0;
			read_dir_reg <= 1'b0;
			sub_reg <= 8'h00;
			wr_stb_reg <= 1'b0;
		end else begin
			wr_stb_reg <= 1'b0;
			if (bus_start) begin
				ser_state_reg <= SER_ADDR;
				bit_cnt_reg <= 4'h0;
				ack_low_reg <= 1'b0;
			end else if (bus_stop) begin
				ser_state_reg <= SER_IDLE;
				ack_low_reg <= 1'b0;
			end else if (scl_rise) begin
				if (ser_state_reg == SER_RDATA_ACK) begin
					nack_reg <= sda_s;
				end else begin
					shift_reg <= {shift_reg[6:0], sda_s};
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
				end
			end else if (scl_fall) begin
				case (ser_state_reg)
				SER_ADDR: begin
					if (byte_done) begin
						// another device's address: stay off the bus
						if (shift_reg[7:1] == own_address) begin
							ser_state_reg <= SER_ADDR_ACK;
							ack_low_reg <= 1'b1;
							read_dir_reg <= shift_reg[0];
						end else begin
							ser_state_reg <= SER_IDLE;
						end
					end
				end
				SER_ADDR_ACK: begin
					ack_low_reg <= 1'b0;
					bit_cnt_reg <= 4'h0;
					if (read_dir_reg) begin
						tx_reg <= rd_data;
						ser_state_reg <= SER_RDATA;
					end else begin
						ser_state_reg <= SER_SUB;
					end
				end
				SER_SUB: begin
					if (byte_done) begin
						sub_reg <= shift_reg;
						ack_low_reg <= 1'b1;
						ser_state_reg <= SER_SUB_ACK;
					end
				end
				SER_SUB_ACK, SER_WDATA_ACK: begin
					ack_low_reg <= 1'b0;
					bit_cnt_reg <= 4'h0;
					if (ser_state_reg == SER_WDATA_ACK) begin
						sub_reg <= sub_reg + 8'h01;
					end
					ser_state_reg <= SER_WDATA;
				end
				SER_WDATA: begin
					if (byte_done) begin
						wr_stb_reg <= 1'b1;
						ack_low_reg <= 1'b1;
						ser_state_reg <= SER_WDATA_ACK;
					end
				end
				SER_RDATA: begin
					if (byte_done) begin
						sub_reg <= sub_reg + 8'h01;
						ser_state_reg <= SER_RDATA_ACK;
					end else begin
						tx_reg <= {tx_reg[6:0], 1'b0};
					end
				end
				SER_RDATA_ACK: begin
					// master nack ends the read burst
					if (nack_reg) begin
						ser_state_reg <= SER_IDLE;
					end else begin
						tx_reg <= rd_data;
						bit_cnt_reg <= 4'h0;
						ser_state_reg <= SER_RDATA;
					end
				end
				default: ser_state_reg <= SER_IDLE;
				endcase
			end
		end
	end

	assign wr_stb = wr_stb_reg;
	assign wr_data = shift_reg;
	assign SDA_OUT = 1'b0;
	assign SDA_OE_N = !(ack_low_reg ||
		((ser_state_reg == SER_RDATA) && !tx_reg[7]));

	// ------------------------------------------------------------
	// line counter, clamp window and pixel trap
	// ------------------------------------------------------------
	logic hs_prev_reg;
	logic [11:0] pix_cnt_reg;
	logic clamp_pulse_reg;

	wire logic hs_edge = hs_s && !hs_prev_reg;
	wire logic internal_clamp = (pix_cnt_reg >= clamp_begin_count) &&
		(pix_cnt_reg < clamp_end_count);
	// external source overrides the window counts completely
	wire logic clamp_next =
		clamp_source_select ? ext_clamp_s : internal_clamp;
	wire logic trap_hit = !global_power_down &&
		(pix_cnt_reg == sample_capture_position);

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			hs_prev_reg <= 1'b0;
			pix_cnt_reg <= PIXEL_COUNT_MAX;
			clamp_pulse_reg <= 1'b0;
		end else begin
			hs_prev_reg <= hs_s;
			// saturate so a missing sync cannot re-trap the line
			if (hs_edge) begin
				pix_cnt_reg <= 12'h000;
			end else if (pix_cnt_reg != PIXEL_COUNT_MAX) begin
				pix_cnt_reg <= pix_cnt_reg + 12'h001;
			end
			clamp_pulse_reg <= clamp_next;
		end
	end

	assign CLAMP_PULSE = clamp_pulse_reg;

	wire logic [7:0] sample_lane [3] =
		'{SAMPLE_IN.ch1, SAMPLE_IN.ch2, SAMPLE_IN.ch3};

	generate
		for (gi = 0; gi < 3; gi++) begin : g_trap
			dcr_capture #(.W(8)) u_cap (
				.clk(CLOCK),
				.rst(RST),
				.load(trap_hit),
				.d(sample_lane[gi]),
				.q(readback[gi])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// oscillator model, composite and display sync
	// ------------------------------------------------------------
	logic [11:0] fb_cnt_reg;
	logic fb_pulse_reg;
	logic synth_clk_reg;
	logic hs_dly_reg;
	logic dhs_reg;
	logic csync_reg;

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			fb_cnt_reg <= 12'h000;
			fb_pulse_reg <= 1'b0;
			synth_clk_reg <= 1'b0;
		end else if (oscillator_disable) begin
			fb_cnt_reg <= 12'h000;
			fb_pulse_reg <= 1'b0;
			synth_clk_reg <= 1'b0;
		end else begin
			// runs whatever the converter clock select says
			synth_clk_reg <= !synth_clk_reg;
			fb_pulse_reg <= (fb_cnt_reg == FEEDBACK_TERM_COUNT - 12'h001);
			if (fb_cnt_reg == FEEDBACK_TERM_COUNT - 12'h001) begin
				fb_cnt_reg <= 12'h000;
			end else begin
				fb_cnt_reg <= fb_cnt_reg + 12'h001;
			end
		end
	end

	wire logic dhs_src = display_sync_mode ? hs_dly_reg : fb_pulse_reg;

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			hs_dly_reg <= 1'b0;
			dhs_reg <= 1'b0;
			csync_reg <= 1'b0;
		end else begin
			// one stage matches the formatter register on the data
			hs_dly_reg <= hs_s;
			dhs_reg <= dhs_src ^ display_sync_polarity;
			csync_reg <= csync_s && !composite_sync_disable &&
				!clamp_ctrl[CLAMP_RANGE_BIT1];
		end
	end

	assign SYNTH_CLOCK_OUT = synth_clk_reg;
	assign DISPLAY_HSYNC_OUT = dhs_reg;
	assign COMPOSITE_SYNC_OUT = csync_reg;

	// ------------------------------------------------------------
	// output formatter
	// ------------------------------------------------------------
	dcr_pixel_s bus_a_reg;
	dcr_pixel_s bus_b_reg;
	dcr_pixel_s prev_pix_reg;
	logic phase_reg;
	logic dclk_reg;

	wire logic half_rate = output_format_mode[1];
	wire dcr_pixel_s pix_422 = '{ch1: SAMPLE_IN.ch1,
		ch2: phase_reg ? SAMPLE_IN.ch3 : SAMPLE_IN.ch2, ch3: 8'h00};

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			phase_reg <= 1'b0;
			dclk_reg <= 1'b1;
		end else begin
			phase_reg <= hs_edge ? 1'b0 : !phase_reg;
			dclk_reg <= half_rate ? phase_reg : 1'b1;
		end
	end

	// power-down freezes the buses at their last values
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			bus_a_reg <= '0;
			bus_b_reg <= '0;
			prev_pix_reg <= '0;
		end else if (!global_power_down) begin
			prev_pix_reg <= SAMPLE_IN;
			case (output_format_mode)
			FMT_24_PARALLEL: bus_a_reg <= SAMPLE_IN;
			FMT_16_422: bus_a_reg <= pix_422;
			FMT_48_INTERLEAVED: begin
				if (phase_reg) begin
					bus_b_reg <= SAMPLE_IN;
				end else begin
					bus_a_reg <= SAMPLE_IN;
				end
			end
			default: begin
				if (phase_reg) begin
					bus_a_reg <= prev_pix_reg;
					bus_b_reg <= SAMPLE_IN;
				end
			end
			endcase
		end
	end

	assign BUS_A = bus_a_reg;
	assign BUS_B = bus_b_reg;
	assign BUS_A_OE_N = global_power_down;
	assign BUS_B_OE_N = !half_rate || global_power_down;
	assign DATA_OUTPUT_CLOCK = dclk_reg;
endmodule

//--- hw/dcr_pkg.sv
// constants, field layout and carrier types of the digitizer register group
// assumes one sampling clock domain; serial bus and sync pins are asynchronous

package dcr_pkg;

	// ------------------------------------------------------------
	// subaddresses
	// ------------------------------------------------------------
	localparam logic [7:0] REG_PLL_CONTROL = 8'h0F;
	localparam logic [7:0] REG_BANK_FIRST = 8'h20;
	localparam logic [7:0] REG_BANK_LAST = 8'h31;
	localparam logic [7:0] REG_CH1_READBACK = 8'h32;
	localparam logic [7:0] REG_CH2_READBACK = 8'h33;
	localparam logic [7:0] REG_CH3_READBACK = 8'h34;
	localparam logic [7:0] REG_OUTPUT_FORMAT = 8'h40;

	// ------------------------------------------------------------
	// index into the contiguous control bank
	// ------------------------------------------------------------
	localparam int BANK_SIZE = 18;
	localparam int IDX_CLAMP_CONTROL = 0;
	localparam int IDX_BEGIN_LOW = 1;
	localparam int IDX_BEGIN_HIGH = 2;
	localparam int IDX_END_LOW = 3;
	localparam int IDX_END_HIGH = 4;
	localparam int IDX_CHAN_FIRST = 5;
	localparam int IDX_CHAN_STRIDE = 3;
	localparam int IDX_TRAP_LOW = 14;
	localparam int IDX_TRAP_HIGH = 15;
	localparam int IDX_POWER_DOWN = 16;
	localparam int IDX_AUX = 17;

	localparam logic [7:0] BANK_RESET [BANK_SIZE] = '{
		8'h2A, 8'h02, 8'h00, 8'h40, 8'h00,
		8'h80, 8'h20, 8'h10, 8'h80, 8'h20, 8'h10, 8'h80, 8'h20, 8'h10,
		8'h04, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] BANK_MASK [BANK_SIZE] = '{
		8'h7F, 8'hFF, 8'h0F, 8'hFF, 8'h0F,
		8'hFF, 8'h3F, 8'h1F, 8'hFF, 8'h3F, 8'h1F, 8'hFF, 8'h3F, 8'h1F,
		8'hFF, 8'h0F, 8'h17, 8'h1F};
	localparam logic [7:0] PLL_CONTROL_RESET = 8'h00;
	localparam logic [7:0] PLL_CONTROL_MASK = 8'h10;
	localparam logic [7:0] OUTPUT_FORMAT_RESET = 8'h00;
	localparam logic [7:0] OUTPUT_FORMAT_MASK = 8'h0F;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CLAMP_SOURCE_BIT = 6;
	localparam int CLAMP_ENABLE_BIT1 = 5;
	localparam int CLAMP_RANGE_BIT1 = 4;
	localparam int CLAMP_ENABLE_BIT2 = 3;
	localparam int CLAMP_RANGE_BIT2 = 2;
	localparam int CLAMP_ENABLE_BIT3 = 1;
	localparam int CLAMP_RANGE_BIT3 = 0;
	localparam int GLOBAL_PD_BIT = 4;
	localparam int REFERENCE_PD_BIT = 2;
	localparam int BANDGAP_PD_BIT = 1;
	localparam int OSC_DISABLE_BIT = 0;
	localparam int CSYNC_DISABLE_BIT = 4;
	localparam int CONV_CLK_SELECT_BIT = 4;
	localparam int SYNC_MODE_BIT = 3;
	localparam int SYNC_POLARITY_BIT = 2;

	localparam logic [1:0] FMT_24_PARALLEL = 2'h0;
	localparam logic [1:0] FMT_16_422 = 2'h1;
	localparam logic [1:0] FMT_48_INTERLEAVED = 2'h2;
	localparam logic [1:0] FMT_48_PARALLEL = 2'h3;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam logic [11:0] FEEDBACK_TERM_COUNT = 12'h320;
	localparam logic [11:0] PIXEL_COUNT_MAX = 12'hFFF;
	localparam logic [6:0] DEVICE_ADDRESS_HIGH = 7'h2C; // arbitrary value

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] ch1;
		logic [7:0] ch2;
		logic [7:0] ch3;
	} dcr_pixel_s;

	typedef struct packed {
		logic [7:0] clamp_level;
		logic [5:0] gain_coarse;
		logic [4:0] gain_fine;
	} dcr_chan_cfg_s;

	typedef enum logic [3:0] {
		SER_IDLE, SER_ADDR, SER_ADDR_ACK, SER_SUB, SER_SUB_ACK,
		SER_WDATA, SER_WDATA_ACK, SER_RDATA, SER_RDATA_ACK
	} dcr_ser_state_e;

endpackage

//--- hw/dcr_sync3.sv
// three-stage pin synchroniser with agreement filter
// assumes d is asynchronous to clk; q changes only when stages 2 and 3 agree
`timescale 1ns/1ps

module dcr_sync3 #(
	parameter logic INIT = 1'b0
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// pin and filtered level
	input wire logic d,
	output logic q
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	logic q_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			s1_reg <= INIT;
			s2_reg <= INIT;
			s3_reg <= INIT;
			q_reg <= INIT;
		end else begin
			s1_reg <= d;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				q_reg <= s3_reg;
			end
		end
	end

	assign q = q_reg;
endmodule

//--- testbench/dcr_regs_props.sv
// port assertions of the digitizer register block
// assumes one sampling clock domain and a synchronous reset
`timescale 1ns/1ps

module dcr_regs_props (
	// clock and reset
	input wire logic CLOCK,
	input wire logic RST,
	// watched outputs
	input wire dcr_pkg::dcr_chan_cfg_s [2:0] CHAN_CFG,
	input wire logic GLOBAL_POWER_DOWN,
	input wire logic REFERENCE_POWER_DOWN,
	input wire logic BANDGAP_POWER_DOWN,
	input wire logic SYNTH_CLOCK_OUT,
	input wire logic SDA_OE_N,
	input wire logic CLAMP_PULSE,
	input wire dcr_pkg::dcr_pixel_s BUS_A,
	input wire logic BUS_A_OE_N,
	input wire logic BUS_B_OE_N,
	input wire logic DATA_OUTPUT_CLOCK
);
	import dcr_pkg::*;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	chk_reset_cfg: assert property (
		$fell(RST) |-> CHAN_CFG == {3{8'h80, 6'h20, 5'h10}})
		else $error("channel setting reset wrong");
	chk_reset_power: assert property (
		$fell(RST) |-> !(GLOBAL_POWER_DOWN | REFERENCE_POWER_DOWN
		| BANDGAP_POWER_DOWN)) else $error("power bits reset wrong");
	chk_bus_a_on: assert property (
		!GLOBAL_POWER_DOWN && !$past(GLOBAL_POWER_DOWN) |-> !BUS_A_OE_N)
		else $error("bus a released while active");
	chk_bus_freeze: assert property (
		GLOBAL_POWER_DOWN [*2] |=> $stable(BUS_A))
		else $error("bus a moved in power down");
	chk_synth_toggle: assert property (
		SYNTH_CLOCK_OUT |=> !SYNTH_CLOCK_OUT)
		else $error("synth clock stuck high");
	// a steady data clock means a full-rate format
	chk_busb_full: assert property (
		DATA_OUTPUT_CLOCK [*4] |-> $past(BUS_B_OE_N, 2))
		else $error("bus b driven at full rate");
	chk_busb_half: assert property (
		!BUS_B_OE_N |-> ##[0:2] !DATA_OUTPUT_CLOCK)
		else $error("bus b driven without half rate clock");
	chk_dclk_rate: assert property (
		!DATA_OUTPUT_CLOCK |-> ##[1:2] DATA_OUTPUT_CLOCK)
		else $error("data clock low too long");
	cover property ($fell(SDA_OE_N));
	cover property ($rose(CLAMP_PULSE));
	cover property (GLOBAL_POWER_DOWN);
	cover property (!BUS_B_OE_N);
endmodule

bind dcr_digitizer_regs dcr_regs_props chk (.CLOCK, .RST, .CHAN_CFG,
	.GLOBAL_POWER_DOWN, .REFERENCE_POWER_DOWN, .BANDGAP_POWER_DOWN,
	.SYNTH_CLOCK_OUT, .SDA_OE_N, .CLAMP_PULSE, .BUS_A, .BUS_A_OE_N,
	.BUS_B_OE_N, .DATA_OUTPUT_CLOCK);

//--- testbench/dcr_sink.sv
// far-side receiver of the digitizer pixel bus
// assumes data_clk is the formatter output clock, sampled on clk
`timescale 1ns/1ps

module dcr_sink (
	// clock and clear
	input wire logic clk,
	input wire logic clr,
	// pixel bus
	input wire dcr_pkg::dcr_pixel_s bus_a,
	input wire logic bus_a_oe_n,
	input wire logic data_clk,
	// what the receiver saw
	output dcr_pkg::dcr_pixel_s held,
	output logic [7:0] edges
);
	import dcr_pkg::*;
	logic clk_d = 1'b1;
	// ------------------------------------------------------------
	// data clock edge count and capture
	// ------------------------------------------------------------
	always @(posedge clk) begin
		clk_d <= data_clk;
		if (clr)
			edges <= 8'h00;
		else if (data_clk && !clk_d)
			edges <= edges + 8'h01;
		// a released bus is not latched
		if (!bus_a_oe_n)
			held <= bus_a;
	end
endmodule

//--- testbench/tb.sv
// self-checking bench of the digitizer register block
// assumes the bench is the only serial master; SDA has a pull-up
`timescale 1ns/1ps

module tb;
	import dcr_pkg::*;
	localparam logic [6:0] DEV = {DEVICE_ADDRESS_HIGH[6:1], 1'b1};
	logic clock = 0, rst = 1, scl = 1, sdm = 1, hs = 0, ecl = 0, cs = 0;
	logic clr = 1, cp_d = 0, s0;
	logic [8:0] rx;
	logic [15:0] mk [3] = '{16'h240F, 16'h263F, 16'h271F};
	dcr_pixel_s smp = 24'h000000, sp, trap, bus_a, bus_b, held;
	logic [7:0] edges;
	int n_clp, n_dhs, n_cyc, mismatches, num_checks;
	wire logic oe_n, clp, gpd, rpd, bpd, ccs, syn, csy, display_hsync_out, a_n, b_n, doc;
	wire sda = sdm & oe_n;

	dcr_digitizer_regs dut (.CLOCK(clock), .RST(rst), .SCL_IN(scl),
		.SDA_IN(sda), .SDA_OUT(), .SDA_OE_N(oe_n), .ADDR_SELECT(1'b1),
		.HS_IN(hs), .EXT_CLAMP_IN(ecl), .CSYNC_SLICE_IN(cs),
		.SAMPLE_IN(smp), .CLAMP_PULSE(clp), .CLAMP_CHANNEL_ENABLE(),
		.CLAMP_MID_RANGE(), .CHAN_CFG(), .GLOBAL_POWER_DOWN(gpd),
		.REFERENCE_POWER_DOWN(rpd), .BANDGAP_POWER_DOWN(bpd),
		.CONVERTER_CLOCK_SELECT(ccs), .SYNTH_CLOCK_OUT(syn),
		.COMPOSITE_SYNC_OUT(csy), .DISPLAY_HSYNC_OUT(display_hsync_out), .BUS_A(bus_a),
		.BUS_B(bus_b), .BUS_A_OE_N(a_n), .BUS_B_OE_N(b_n),
		.DATA_OUTPUT_CLOCK(doc));
	dcr_sink sink (.clk(clock), .clr(clr), .bus_a(bus_a),
		.bus_a_oe_n(a_n), .data_clk(doc), .held(held), .edges(edges));

	initial begin
		forever #50 clock = ~clock;
	end
	// ------------------------------------------------------------
	// sample source, monitor and hang limit
	// ------------------------------------------------------------
	always @(posedge clock) begin
		sp = smp;
		#1;
		if (clp && !cp_d)
			trap = sp;
		cp_d = clp;
		n_clp += clp;
		n_dhs += display_hsync_out;
		n_cyc++;
		#4;
		smp <= smp + 24'h010307;
		if (n_cyc == 90000) begin
			mismatches++;
			results;
		end
	end
	// ------------------------------------------------------------
	// serial access tasks
	// ------------------------------------------------------------
	task automatic w(input int n);
		repeat (n) @(posedge clock);
		#5;
	endtask
	task automatic tick(input logic v);
		w(6);
		scl = v;
		w(6);
	endtask
	task automatic start;
		sdm = 1;
		tick(1);
		sdm = 0;
		tick(0);
	endtask
	task automatic stop;
		sdm = 0;
		tick(1);
		sdm = 1;
		w(12);
	endtask
	task automatic xfer(input logic [8:0] d);
		for (int i = 8; i >= 0; i--) begin
			sdm = d[i];
			tick(1);
			rx[i] = sda;
			tick(0);
		end
	endtask
	task automatic chk(string nm, logic [23:0] e, logic [23:0] g);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic xa(input logic [7:0] d);
		xfer({d, 1'b1});
		chk("ack", 0, rx[0]);
	endtask
	task automatic wr(input logic [7:0] a, d);
		start;
		xa({DEV, 1'b0});
		xa(a);
		xa(d);
		stop;
	endtask
	task automatic rc(string nm, logic [7:0] a, e);
		start;
		xa({DEV, 1'b0});
		xa(a);
		start;
		xa({DEV, 1'b1});
		xfer(9'h1FF);
		stop;
		chk(nm, e, rx[8:1]);
	endtask
	task automatic line(input int n);
		hs = 1;
		w(n);
		hs = 0;
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		w(10);
		rst = 0;
		w(5);
		for (int i = 0; i < BANK_SIZE; i++)
			rc("bank", REG_BANK_FIRST + 8'(i), BANK_RESET[i]);
		rc("format", REG_OUTPUT_FORMAT, 8'h00);
		foreach (mk[i]) begin
			wr(mk[i][15:8], 8'hFF);
			rc("mask", mk[i][15:8], mk[i][7:0]);
		end
		wr(8'h24, 8'h00);
		wr(REG_CH1_READBACK, 8'h5A);
		rc("unmapped", 8'h50, 8'h00);
		wr(8'h21, 8'h04);
		n_clp = 0;
		line(30);
		w(100);
		chk("clamp width", 60, n_clp);
		rc("trap1", REG_CH1_READBACK, trap.ch1);
		rc("trap2", REG_CH2_READBACK, trap.ch2);
		rc("trap3", REG_CH3_READBACK, trap.ch3);
		wr(8'h20, 8'h6A);
		n_clp = 0;
		line(30);
		ecl = 1;
		w(20);
		ecl = 0;
		w(20);
		chk("ext clamp", 20, n_clp);
		wr(8'h20, 8'h2A);
		cs = 1;
		w(10);
		chk("csync on", 1, csy);
		wr(8'h31, 8'h10);
		chk("csync off", 0, csy);
		wr(8'h30, 8'h16);
		chk("power", 3'h7, {gpd, rpd, bpd});
		chk("bus a off", 1, a_n);
		wr(8'h30, 8'h00);
		chk("power", 3'h0, {gpd, rpd, bpd});
		wr(REG_PLL_CONTROL, 8'h10);
		chk("ext clock", 1, ccs);
		s0 = syn;
		w(1);
		chk("synth", !s0, syn);
		wr(8'h30, 8'h01);
		chk("synth off", 0, syn);
		wr(8'h30, 8'h00);
		n_dhs = 0;
		w(800);
		chk("sync pulses", 1, n_dhs);
		wr(REG_OUTPUT_FORMAT, 8'h04);
		n_dhs = 0;
		w(800);
		chk("sync inverted", 799, n_dhs);
		wr(REG_OUTPUT_FORMAT, 8'h08);
		n_dhs = 0;
		line(30);
		w(20);
		chk("sync follows", 30, n_dhs);
		for (int m = 0; m < 4; m++) begin
			wr(REG_OUTPUT_FORMAT, 8'(m));
			chk("bus b off", m < 2, b_n);
			if (m == 0)
				chk("bus a", sp, bus_a);
			if (m == 0)
				chk("sink held", sp - 24'h010307, held);
			if (m == 1)
				chk("lane 3", 0, bus_a.ch3);
			clr = 1;
			w(1);
			clr = 0;
			w(20);
			chk("clock edges", m < 2 ? 0 : 10, edges);
			// parallel pair: bus a holds the sample one clock before bus b
			if (m == 3)
				chk("pair", bus_b - 24'h010307, bus_a);
		end
		results;
	end
endmodule
